// File: common/ebp_pkg.sv
// Constants and types for the external bus pin controller.
// Assumes one 100 MHz clock and a synchronous active-low reset.
// What this block does
// - Strap low gives 16-bit, high 8-bit bus
// - Mode pin at reset picks single-chip or microprocessor
// - Separate bus uses D8-D15 only when 16-bit
// - Address bits 0 to 19 on dedicated outputs
// - 8-bit multiplexed: A0-A7 then D0-D7 shared
// - 16-bit multiplexed: A1-A8 shared with D0-D7
// - Four active-low area selects name the area
// - Split strobes: even low strobe, odd high strobe
// - Single strobe: write strobe plus odd enable
// - Read strobe low while reading, both modes
// - Address-latch strobe output captures the address
// - Hold acknowledge low while bus is held
// - Access waits while ready input is low
// - Reset input low resets the block

package ebp_pkg;

  // ---------------------------------------------------------------
  // Widths and reset values
  // ---------------------------------------------------------------
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int AREAS = 4;
  localparam int SYNC_W = DATA_W + 4;
  localparam logic [3:0] AREA_NONE = 4'hf;
  localparam logic [SYNC_W-1:0] SYNC_RST = 20'hc0000;
  localparam logic [1:0] MODE_SETTLE = 2'h2;

  // ---------------------------------------------------------------
  // Phase timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int ADDR_NS = 10;
  localparam int LATCH_NS = 10;
  localparam int STROBE_MIN_NS = 30;

  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    cyc_up = (c < 1) ? 1 : c;
  endfunction : cyc_up

  localparam int ADDR_CYC = cyc_up(ADDR_NS);
  localparam int LATCH_CYC = cyc_up(LATCH_NS);
  localparam int STROBE_CYC = cyc_up(STROBE_MIN_NS);
  localparam logic [3:0] CNT_ADDR = 4'(ADDR_CYC - 1);
  localparam logic [3:0] CNT_LATCH = 4'(LATCH_CYC - 1);
  localparam logic [3:0] CNT_STROBE = 4'(STROBE_CYC - 1);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_LATCH = 6'h04,
    ST_STROBE = 6'h08,
    ST_RECOVER = 6'h10,
    ST_HOLD = 6'h20
  } ebp_state_t;

  typedef struct packed {
    ebp_state_t st;
    logic [3:0] cnt;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic write;
    logic word;
    logic [1:0] area;
    logic second;
    logic mux;
    logic single;
    logic [DATA_W-1:0] rdata;
    logic rvalid;
    logic [1:0] init;
    logic mode_ok;
    logic micro;
    logic bus8;
    logic [ADDR_W-1:0] p_addr;
    logic [DATA_W-1:0] p_dout;
    logic [DATA_W-1:0] p_oe;
    logic [3:0] p_cs_n;
    logic p_wre_n;
    logic p_wro_n;
    logic p_bhe_n;
    logic p_rd_n;
    logic p_ale;
    logic p_bus_hold_ack_n;
  } ebp_core_t;

  localparam ebp_core_t CORE_RST = '{st: ST_IDLE, p_cs_n: AREA_NONE, p_wre_n: 1'b1, p_wro_n: 1'b1,
                                     p_bhe_n: 1'b1, p_rd_n: 1'b1, p_bus_hold_ack_n: 1'b1, default: '0};

endpackage : ebp_pkg

// File: logic/ebp_sync.sv
// Two-stage synchroniser for pin inputs.
// Assumes inputs asynchronous to mclk; reset is synchronous.
`timescale 1ns/1ps
module ebp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import ebp_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } ebp_sync_t;

  ebp_sync_t r_reg;
  ebp_sync_t r_next;

  always_comb begin
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= {RST_VAL, RST_VAL};
    end else begin
      r_reg <= r_next;
    end
  end

  assign q = r_reg.s2;

endmodule : ebp_sync

// File: logic/ebp_ctrl.sv
// External bus pin controller: sequences one access at a time onto
// the address, data, select and strobe pins.
// Assumes a same-clock requester on the user side and asynchronous
// pins on the bus side.
`timescale 1ns/1ps
module ebp_ctrl (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic processor_mode_pin,
  input wire logic width_strap_pin,
  input wire logic ext_ready_n,
  input wire logic hold_req_n,
  input wire logic [ebp_pkg::DATA_W-1:0] data_in,
  input wire logic mux_mode,
  input wire logic strobe_single,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_word,
  input wire logic [ebp_pkg::ADDR_W-1:0] req_addr,
  input wire logic [1:0] req_area,
  input wire logic [ebp_pkg::DATA_W-1:0] req_wdata,
  output logic resp_valid,
  output logic [ebp_pkg::DATA_W-1:0] resp_rdata,
  output logic single_chip,
  output logic bus_8bit,
  output logic [ebp_pkg::ADDR_W-1:0] addr_out,
  output logic [ebp_pkg::DATA_W-1:0] data_out,
  output logic [ebp_pkg::DATA_W-1:0] data_oe,
  output logic [ebp_pkg::AREAS-1:0] area_select_n,
  output logic even_write_strobe_n,
  output logic odd_write_strobe_n,
  output logic odd_byte_enable_n,
  output logic read_strobe_n,
  output logic addr_latch,
  output logic bus_hold_ack_n
);
  import ebp_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic s_hold_n;
  logic s_rdy_n;
  logic s_pmode;
  logic s_width;
  logic [DATA_W-1:0] s_data;

  ebp_sync #(
    .WIDTH(SYNC_W),
    .RST_VAL(SYNC_RST)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .d({hold_req_n, ext_ready_n, processor_mode_pin, width_strap_pin, data_in}),
    .q(sync_q)
  );

  assign s_hold_n = sync_q[SYNC_W-1];
  assign s_rdy_n = sync_q[SYNC_W-2];
  assign s_pmode = sync_q[SYNC_W-3];
  assign s_width = sync_q[SYNC_W-4];
  assign s_data = sync_q[DATA_W-1:0];

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  ebp_core_t r_reg;
  ebp_core_t r_next;

  assign req_ready = (r_reg.st == ST_IDLE) && r_reg.mode_ok && r_reg.micro && s_hold_n;

  always_comb begin
    logic even_sel;
    logic odd_sel;
    logic odd_acc;
    logic act;
    logic strb;
    logic aph;
    even_sel = 1'b0;
    odd_sel = 1'b0;
    odd_acc = 1'b0;
    act = 1'b0;
    strb = 1'b0;
    aph = 1'b0;
    r_next = r_reg;
    r_next.rvalid = 1'b0;
    // Mode straps caught once the synchroniser holds real pin levels
    if (!r_reg.mode_ok) begin
      if (r_reg.init == MODE_SETTLE) begin
        r_next.mode_ok = 1'b1;
        r_next.micro = s_pmode;
        r_next.bus8 = s_width;
      end else begin
        r_next.init = r_reg.init + 2'h1;
      end
    end
    case (r_reg.st)
      ST_IDLE: begin
        if (!s_hold_n) begin
          r_next.st = ST_HOLD;
        end else if (req_ready && req_valid) begin
          r_next.st = ST_ADDR;
          r_next.cnt = CNT_ADDR;
          r_next.addr = {req_addr[ADDR_W-1:1], req_addr[0] & ~(req_word & ~r_reg.bus8)};
          r_next.wdata = req_wdata;
          r_next.write = req_write;
          r_next.word = req_word;
          r_next.area = req_area;
          r_next.second = 1'b0;
          r_next.mux = mux_mode;
          r_next.single = strobe_single;
          r_next.rdata = '0;
        end
      end
      ST_ADDR: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          r_next.st = ST_LATCH;
          r_next.cnt = CNT_LATCH;
        end
      end
      ST_LATCH: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else begin
          r_next.st = ST_STROBE;
          r_next.cnt = CNT_STROBE;
        end
      end
      ST_STROBE: begin
        if (r_reg.cnt != 4'h0) begin
          r_next.cnt = r_reg.cnt - 4'h1;
        end else if (s_rdy_n) begin
          r_next.st = ST_RECOVER;
          if (!r_reg.write) begin
            if (r_reg.bus8 && r_reg.second) begin
              r_next.rdata[15:8] = s_data[7:0];
            end else if (r_reg.bus8 || !r_reg.word) begin
              r_next.rdata = {8'h00, (!r_reg.bus8 && r_reg.addr[0]) ? s_data[15:8] : s_data[7:0]};
            end else begin
              r_next.rdata = s_data;
            end
          end
        end
      end
      ST_RECOVER: begin
        if (r_reg.bus8 && r_reg.word && !r_reg.second) begin
          // 8-bit bus: high byte follows at the next address
          r_next.second = 1'b1;
          r_next.addr = r_reg.addr + 20'h00001;
          r_next.st = ST_ADDR;
          r_next.cnt = CNT_ADDR;
        end else begin
          r_next.rvalid = 1'b1;
          r_next.st = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (s_hold_n) begin
          r_next.st = ST_IDLE;
        end
      end
      default: begin
        r_next.st = ST_IDLE;
      end
    endcase

    // Registered pin values follow the next state
    aph = (r_next.st == ST_ADDR) || (r_next.st == ST_LATCH);
    strb = (r_next.st == ST_STROBE);
    act = aph || strb;
    even_sel = r_next.bus8 | r_next.word | ~r_next.addr[0];
    odd_sel = ~r_next.bus8 & (r_next.word | r_next.addr[0]);
    odd_acc = r_next.bus8 ? r_next.addr[0] : odd_sel;
    r_next.p_addr = r_next.addr;
    r_next.p_cs_n = act ? ~(4'h1 << r_next.area) : AREA_NONE;
    r_next.p_ale = (r_next.st == ST_ADDR);
    r_next.p_rd_n = ~(strb & ~r_next.write);
    r_next.p_wre_n = ~(strb & r_next.write & (r_next.single | even_sel));
    r_next.p_wro_n = ~(strb & r_next.write & ~r_next.single & odd_sel);
    r_next.p_bhe_n = ~(act & r_next.single & odd_acc);
    r_next.p_bus_hold_ack_n = (r_next.st != ST_HOLD);
    if (r_next.mux && aph) begin
      r_next.p_dout = {8'h00, r_next.bus8 ? r_next.addr[7:0] : r_next.addr[8:1]};
      r_next.p_oe = 16'h00ff;
    end else if (strb && r_next.write) begin
      if (r_next.bus8) begin
        r_next.p_dout = {8'h00, r_next.second ? r_next.wdata[15:8] : r_next.wdata[7:0]};
        r_next.p_oe = 16'h00ff;
      end else begin
        r_next.p_dout = r_next.word ? r_next.wdata : {r_next.wdata[7:0], r_next.wdata[7:0]};
        r_next.p_oe = {{8{odd_sel}}, {8{even_sel}}};
      end
    end else begin
      r_next.p_dout = '0;
      r_next.p_oe = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      r_reg <= CORE_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign resp_valid = r_reg.rvalid;
  assign resp_rdata = r_reg.rdata;
  assign single_chip = ~r_reg.micro;
  assign bus_8bit = r_reg.bus8;
  assign addr_out = r_reg.p_addr;
  assign data_out = r_reg.p_dout;
  assign data_oe = r_reg.p_oe;
  assign area_select_n = r_reg.p_cs_n;
  assign even_write_strobe_n = r_reg.p_wre_n;
  assign odd_write_strobe_n = r_reg.p_wro_n;
  assign odd_byte_enable_n = r_reg.p_bhe_n;
  assign read_strobe_n = r_reg.p_rd_n;
  assign addr_latch = r_reg.p_ale;
  assign bus_hold_ack_n = r_reg.p_bus_hold_ack_n;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sequence seq_addr_phase;
    addr_latch ##1 (!addr_latch && read_strobe_n && even_write_strobe_n && odd_write_strobe_n);
  endsequence

  sequence seq_strobe_wait;
    (r_reg.st == ST_STROBE) && (r_reg.cnt == 4'h0) && !s_rdy_n;
  endsequence

  sequence seq_read_pulse;
    (!read_strobe_n && area_select_n != AREA_NONE) [*3];
  endsequence

  AST_LATCH_BEFORE_DATA:
    assert property ($rose(addr_latch) |-> seq_addr_phase)
    else $error("Address latch not released before strobes");

  AST_LATCH_ADDR_PHASE:
    assert property (addr_latch |-> area_select_n != AREA_NONE && read_strobe_n && even_write_strobe_n)
    else $error("Address latch outside an address phase");

  AST_IDLE_QUIET:
    assert property (area_select_n == AREA_NONE |->
                     read_strobe_n && even_write_strobe_n && odd_write_strobe_n && odd_byte_enable_n)
    else $error("Strobe active with no area selected");

  AST_SINGLE_CHIP_QUIET:
    assert property (single_chip |-> area_select_n == AREA_NONE && !req_ready)
    else $error("Bus access in single-chip mode");

  AST_WAIT_HOLDS:
    assert property (seq_strobe_wait |=> $stable(area_select_n) && (r_reg.st == ST_STROBE))
    else $error("Access ended while ready was low");

  AST_HOLD_ACK:
    assert property (!bus_hold_ack_n |-> data_oe == '0 && area_select_n == AREA_NONE && read_strobe_n)
    else $error("Bus driven during hold");

  AST_BUS8_LANES:
    assert property (bus_8bit |-> data_oe[15:8] == 8'h00)
    else $error("Upper data lanes driven on 8-bit bus");

  AST_SPLIT_ODD:
    assert property (!odd_write_strobe_n |-> !bus_8bit && !r_reg.single && odd_byte_enable_n
                     && (r_reg.word || r_reg.addr[0]))
    else $error("Odd write strobe on wrong access");

  AST_SINGLE_BHE:
    assert property (!even_write_strobe_n && r_reg.single |->
                     odd_write_strobe_n && (odd_byte_enable_n == !(bus_8bit ? r_reg.addr[0]
                     : (r_reg.word || r_reg.addr[0]))))
    else $error("Odd byte enable wrong in single-strobe write");

  AST_MUX8_ADDR:
    assert property (addr_latch && r_reg.mux && bus_8bit |-> data_out[7:0] == addr_out[7:0])
    else $error("8-bit multiplexed address wrong");

  AST_MUX16_ADDR:
    assert property (addr_latch && r_reg.mux && !bus_8bit |-> data_out[7:0] == addr_out[8:1])
    else $error("16-bit multiplexed address wrong");

  AST_ONE_AREA:
    assert property (area_select_n != AREA_NONE |-> $onehot(~area_select_n))
    else $error("More than one area selected");

  AST_READ_STROBE:
    assert property ((r_reg.st == ST_STROBE) && !r_reg.write |-> !read_strobe_n && even_write_strobe_n)
    else $error("Read strobe missing during read");

  AST_RESET:
    assert property (@(posedge mclk) disable iff (1'b0) !rst_n |=> area_select_n == AREA_NONE
                     && bus_hold_ack_n && !resp_valid)
    else $error("Outputs not idle after reset");

  AST_READ_WIDTH:
    assert property ($fell(read_strobe_n) |-> seq_read_pulse)
    else $error("Read strobe shorter than its minimum");

  AST_WIDTH_FIXED:
    assert property (r_reg.mode_ok |=> $stable(bus_8bit) && r_reg.mode_ok)
    else $error("Bus width changed after it was caught");

endmodule : ebp_ctrl

// File: testbench/ebp_mem.sv
// Memory model for the far side of the external bus pins.
// Assumes registered strobes from ebp_ctrl; wait cycles set by the bench.
`timescale 1ns/1ps
module ebp_mem (
  input wire logic mclk,
  input wire logic bus_8bit,
  input wire logic strobe_single,
  input wire logic [3:0] wait_cyc,
  input wire logic [ebp_pkg::ADDR_W-1:0] addr_out,
  input wire logic [ebp_pkg::DATA_W-1:0] data_out,
  input wire logic even_write_strobe_n,
  input wire logic odd_write_strobe_n,
  input wire logic odd_byte_enable_n,
  input wire logic read_strobe_n,
  input wire logic addr_latch,
  output logic [ebp_pkg::DATA_W-1:0] data_in,
  output logic ext_ready_n,
  output logic [7:0] latched
);
  import ebp_pkg::*;
  logic [7:0] mb [0:255];
  logic [3:0] wcnt;
  logic [7:0] a;
  logic [15:0] rv;
  logic [15:0] last;
  logic idle;
  // ---------------------------------------------------------------
  // Byte store, wait counter, released data lines
  // ---------------------------------------------------------------
  initial begin
    for (int i = 0; i < 256; i++) begin
      mb[i] = 8'(i) ^ 8'h5a;
    end
    wcnt = 4'h0;
    last = 16'h0000;
    latched = 8'h00;
  end
  assign a = addr_out[7:0];
  assign idle = read_strobe_n & even_write_strobe_n & odd_write_strobe_n;
  assign rv = bus_8bit ? {8'h00, mb[a]} : {mb[a | 8'h01], mb[a & 8'hfe]};
  // Released lines toggle so a stale value cannot pass
  assign data_in = read_strobe_n ? ~last : rv;
  assign ext_ready_n = (wcnt == 4'h0);
  always @(posedge mclk) begin
    last <= data_in;
    wcnt <= idle ? wait_cyc : wcnt - 4'(wcnt != 4'h0);
    if (addr_latch) begin
      latched <= data_out[7:0];
    end
    if (bus_8bit) begin
      if (!even_write_strobe_n) mb[a] <= data_out[7:0];
    end else if (strobe_single) begin
      if (!even_write_strobe_n && !a[0]) mb[a & 8'hfe] <= data_out[7:0];
      if (!even_write_strobe_n && !odd_byte_enable_n) mb[a | 8'h01] <= data_out[15:8];
    end else begin
      if (!even_write_strobe_n) mb[a & 8'hfe] <= data_out[7:0];
      if (!odd_write_strobe_n) mb[a | 8'h01] <= data_out[15:8];
    end
  end
endmodule : ebp_mem

// File: testbench/tb_top.sv
// Self-checking bench for ebp_ctrl with the memory model on its pins.
// Assumes one 100 MHz clock; inputs change at the falling edge.
`timescale 1ns/1ps
module tb_top;
  import ebp_pkg::*;
  logic mclk, rst_n = 1'b0, processor_mode_pin = 1'b1, width_strap_pin = 1'b0;
  logic hold_req_n = 1'b1;
  logic mux_mode = 1'b0, strobe_single = 1'b0, req_valid = 1'b0, req_write = 1'b0, req_word = 1'b0;
  logic [1:0] req_area = 2'h0;
  logic [3:0] wait_cyc = 4'h0, area_select_n, sel, stb;
  logic [ADDR_W-1:0] req_addr = 20'h00000, addr_out, a_seen;
  logic [DATA_W-1:0] req_wdata = 16'h0000, data_in, resp_rdata, data_out, data_oe, rd, oe;
  logic req_ready, resp_valid, single_chip, bus_8bit, even_write_strobe_n, odd_write_strobe_n;
  logic odd_byte_enable_n, read_strobe_n, addr_latch, bus_hold_ack_n, ext_ready_n;
  logic [7:0] latched;
  int miscompares = 0, n_compared = 0, lat;

  ebp_ctrl u_ebp_ctrl (.mclk, .rst_n, .processor_mode_pin, .width_strap_pin, .ext_ready_n, .hold_req_n,
    .data_in, .mux_mode, .strobe_single, .req_valid, .req_ready, .req_write, .req_word, .req_addr,
    .req_area, .req_wdata, .resp_valid, .resp_rdata, .single_chip, .bus_8bit, .addr_out, .data_out,
    .data_oe, .area_select_n, .even_write_strobe_n, .odd_write_strobe_n, .odd_byte_enable_n,
    .read_strobe_n, .addr_latch, .bus_hold_ack_n);
  ebp_mem u_ebp_mem (.mclk, .bus_8bit, .strobe_single, .wait_cyc, .addr_out, .data_out,
    .even_write_strobe_n, .odd_write_strobe_n, .odd_byte_enable_n, .read_strobe_n, .addr_latch,
    .data_in, .ext_ready_n, .latched);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic do_reset(input logic pm, input logic st);
    @(negedge mclk);
    rst_n = 1'b0;
    processor_mode_pin = pm;
    width_strap_pin = st;
    repeat (6) @(negedge mclk);
    check(area_select_n, 4'hf);
    check({read_strobe_n, even_write_strobe_n, odd_write_strobe_n, bus_hold_ack_n, req_ready}, 5'h1e);
    rst_n = 1'b1;
    repeat (8) @(negedge mclk);
    check(bus_8bit, st);
    check(single_chip, !pm);
  endtask : do_reset

  task automatic acc(input logic w, input logic wd, input logic [19:0] ad, input logic [15:0] dt,
                     input logic [1:0] ar);
    int n;
    n = 0;
    sel = 4'hf;
    stb = 4'hf;
    oe = 16'h0000;
    a_seen = 20'hfffff;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 50) miscompares++;
    req_valid = 1'b1;
    req_write = w;
    req_word = wd;
    req_addr = ad;
    req_wdata = dt;
    req_area = ar;
    @(negedge mclk);
    req_valid = 1'b0;
    lat = 1;
    while (resp_valid !== 1'b1 && lat < 60) begin
      sel = sel & area_select_n;
      stb = stb & {even_write_strobe_n, odd_write_strobe_n, odd_byte_enable_n, read_strobe_n};
      oe = oe | data_oe;
      if (addr_latch === 1'b1 && a_seen === 20'hfffff) a_seen = addr_out;
      @(negedge mclk);
      lat++;
    end
    rd = resp_rdata;
    if (lat >= 60) miscompares++;
  endtask : acc

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_split16;
    acc(1'b1, 1'b1, 20'hfa5c3, 16'hbeef, 2'd1);
    check(20'(lat), 20'h7);
    check(sel, 4'hd);
    check(a_seen, 20'hfa5c2);
    check(stb, 4'h3);
    check(oe, 16'hffff);
    check({u_ebp_mem.mb[8'hc3], u_ebp_mem.mb[8'hc2]}, 16'hbeef);
    acc(1'b1, 1'b0, 20'h00011, 16'h7777, 2'd2);
    check(sel, 4'hb);
    check(stb, 4'hb);
    check(oe, 16'hff00);
    check(u_ebp_mem.mb[8'h10], 8'h4a);
    check(u_ebp_mem.mb[8'h11], 8'h77);
    acc(1'b0, 1'b1, 20'hfa5c2, 16'h0000, 2'd3);
    check(rd, 16'hbeef);
    check(stb, 4'he);
    check(sel, 4'h7);
  endtask : t_split16

  task automatic t_wait;
    wait_cyc = 4'h6;
    acc(1'b0, 1'b0, 20'h00031, 16'h0000, 2'd0);
    check(20'(lat), 20'hd);
    check(rd, 16'h006b);
    wait_cyc = 4'h0;
  endtask : t_wait

  task automatic t_single16;
    strobe_single = 1'b1;
    acc(1'b1, 1'b0, 20'h00041, 16'h3c3c, 2'd0);
    check(stb, 4'h5);
    check(u_ebp_mem.mb[8'h40], 8'h1a);
    acc(1'b0, 1'b1, 20'h00040, 16'h0000, 2'd0);
    check(rd, 16'h3c1a);
    check(stb, 4'hc);
    strobe_single = 1'b0;
  endtask : t_single16

  task automatic t_hold;
    @(negedge mclk);
    hold_req_n = 1'b0;
    repeat (6) @(negedge mclk);
    check({bus_hold_ack_n, req_ready, data_oe}, 20'h0);
    hold_req_n = 1'b1;
    repeat (6) @(negedge mclk);
    check({bus_hold_ack_n, req_ready}, 20'h3);
  endtask : t_hold

  task automatic t_mux16;
    mux_mode = 1'b1;
    acc(1'b1, 1'b0, 20'h001a6, 16'h5555, 2'd1);
    check(latched, 8'hd3);
    check(u_ebp_mem.mb[8'ha6], 8'h55);
  endtask : t_mux16

  task automatic t_mux8;
    strobe_single = 1'b1;
    acc(1'b1, 1'b1, 20'h12345, 16'ha1b2, 2'd0);
    check(latched, 8'h46);
    check(oe, 16'h00ff);
    check(stb, 4'h5);
    check({u_ebp_mem.mb[8'h46], u_ebp_mem.mb[8'h45]}, 16'ha1b2);
    acc(1'b0, 1'b1, 20'h12345, 16'h0000, 2'd0);
    check(rd, 16'ha1b2);
  endtask : t_mux8

  initial begin
    do_reset(1'b1, 1'b0);
    t_split16();
    t_wait();
    t_single16();
    t_hold();
    t_mux16();
    do_reset(1'b1, 1'b1);
    t_mux8();
    do_reset(1'b0, 1'b0);
    check(req_ready, 1'b0);
    wrap_up();
  end

  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule : tb_top
